// >>> logic/ptit_pkg.sv
// Package for the periodic tick interrupt timer.
// Holds register offsets, field layouts, reset values and the tap table.
// Assumes a 32-bit APB register bus and a prescaler count on the system clock.
package ptit_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] PTIT_OFS_CONTROL = 12'h000;
    localparam logic [11:0] PTIT_OFS_STATUS = 12'h004;
    localparam logic [11:0] PTIT_OFS_CLEAR = 12'h008;
    localparam logic [11:0] PTIT_OFS_IRQ_ENABLE = 12'h00C;
    localparam int PTIT_ADDR_W = 12;

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int PTIT_CTRL_W = 8;
    localparam int PTIT_RATE_LSB = 0;
    localparam int PTIT_RATE_W = 3;
    localparam int PTIT_ENABLE_BIT = 3;
    localparam logic [7:0] PTIT_CTRL_RESET = 8'h00;

    // ----------------------------------------------------------------
    // event / status fields
    // ----------------------------------------------------------------
    localparam int PTIT_EVT_W = 2;
    localparam int PTIT_EVT_TICK = 0;
    localparam int PTIT_EVT_OVERRUN = 1;
    localparam logic [1:0] PTIT_EVT_RESET = 2'h0;

    // ----------------------------------------------------------------
    // prescaler taps
    // ----------------------------------------------------------------
    // divisor exponent per rate code with the clock gear low; gear high adds one
    localparam int PTIT_PRESCALER_W = 24;
    localparam logic [4:0] PTIT_EXP_TABLE [8] = '{
        5'h17, 5'h15, 5'h10, 5'h0E, 5'h0D, 5'h0C, 5'h0B, 5'h09
    };

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic [2:0] rate;
    } ptit_ctrl_t;

    typedef struct packed {
        logic overrun;
        logic tick;
    } ptit_evt_t;

endpackage

// >>> logic/ptit_timer.sv
// Periodic tick interrupt timer with its APB register slave.
// Assumes prescaler_count_in is a free-running up-counter clocked by
// clk_sys_in (the high frequency clock) that this block never clears.
//
// Overview of operation
// R1: The block raises a tick interrupt request from a chosen prescaler stage as a time base.
// R2: Once enabled, a tick is raised at the first falling edge of the chosen tap and every later one.
// R3: Enabling never clears the shared prescaler, so the first tick may come early.
// R4: Software changes the rate only while disabled, and not in the write that disables.
// R5: A single write of a new rate together with the enable bit starts ticking at that rate.
// R6: Codes 000 to 111 tap fc/2^23,2^21,2^16,2^14,2^13,2^12,2^11,2^9; gear high doubles each.
// R7: Software always writes zero to bits 7 to 4 of the control register.
// R8: Reset clears the control register to zero: disabled, rate code 000.
// R9: The control register holds enable at bit 3 and the rate select in bits 2 to 0, read/write.
// R10: With enable at zero no tick requests are raised, whatever the prescaler does.
//
// Implementation choices: the placing of the registers and the APB slave port.

`timescale 1ns/10ps

module ptit_timer
#(
    parameter int PRESCALER_W = ptit_pkg::PTIT_PRESCALER_W
)
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ptit_pkg::PTIT_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // prescaler and clock gear, both on clk_sys_in
    input wire logic [PRESCALER_W-1:0] prescaler_count_in,
    input wire logic clock_gear_divider_select_in,
    // interrupt side
    output logic tick_interrupt_request_out,
    output logic irq_out
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    ptit_pkg::ptit_ctrl_t ctrl_q;
    ptit_pkg::ptit_ctrl_t ctrl_d;
    ptit_pkg::ptit_evt_t status_q;
    ptit_pkg::ptit_evt_t status_d;
    ptit_pkg::ptit_evt_t irq_en_q;
    ptit_pkg::ptit_evt_t irq_en_d;
    ptit_pkg::ptit_evt_t evt_set;
    ptit_pkg::ptit_evt_t evt_clr;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic tap_prev_q;
    logic tap_prev_d;
    logic armed_q;
    logic armed_d;
    logic tick_q;
    logic tick_d;
    logic irq_q;
    logic irq_d;
    logic setup_phase;
    logic wr_take;
    logic addr_hit;
    logic [4:0] tap_index;
    logic tap_now;
    logic tick_fire;
    logic [7:0] tap_by_code;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    // zero wait state: pready rises in the first access cycle
    // a setup seen while ready still stands would answer one transfer twice
    assign setup_phase = psel_in && !penable_in && !pready_q;
    // writes land only in the answered access cycle, and an unmapped one never lands
    assign wr_take = psel_in && penable_in && pready_q && pwrite_in && !pslverr_q;

    always_comb
    begin
        case (paddr_in)
            ptit_pkg::PTIT_OFS_CONTROL,
            ptit_pkg::PTIT_OFS_STATUS,
            ptit_pkg::PTIT_OFS_CLEAR,
            ptit_pkg::PTIT_OFS_IRQ_ENABLE:
                addr_hit = 1'b1;
            default:
                addr_hit = 1'b0;
        endcase
    end

    always_comb
    begin
        pready_d = setup_phase;
        pslverr_d = setup_phase && !addr_hit;
        prdata_d = prdata_q;
        if (setup_phase)
        begin
            prdata_d = 32'h0000_0000;
            if (!pwrite_in)
            begin
                case (paddr_in)
                    ptit_pkg::PTIT_OFS_CONTROL:
                    begin
                        prdata_d[ptit_pkg::PTIT_ENABLE_BIT] = ctrl_q.enable; // [R9]
                        prdata_d[ptit_pkg::PTIT_RATE_LSB +: ptit_pkg::PTIT_RATE_W] = ctrl_q.rate;
                    end
                    ptit_pkg::PTIT_OFS_STATUS:
                        prdata_d[ptit_pkg::PTIT_EVT_W-1:0] = status_q;
                    ptit_pkg::PTIT_OFS_IRQ_ENABLE:
                        prdata_d[ptit_pkg::PTIT_EVT_W-1:0] = irq_en_q;
                    default:
                        prdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // ----------------------------------------------------------------
    // control, clear and enable registers
    // ----------------------------------------------------------------
    // upper control bits are not stored; software is expected to write zeros there
    always_comb
    begin
        ctrl_d = ctrl_q;
        irq_en_d = irq_en_q;
        evt_clr = ptit_pkg::PTIT_EVT_RESET;
        if (wr_take && pstrb_in[0])
        begin
            case (paddr_in)
                ptit_pkg::PTIT_OFS_CONTROL:
                begin
                    ctrl_d.enable = pwdata_in[ptit_pkg::PTIT_ENABLE_BIT]; // [R9]
                    // rate and enable land together, so a combined write starts at the new rate
                    ctrl_d.rate = pwdata_in[ptit_pkg::PTIT_RATE_LSB +: ptit_pkg::PTIT_RATE_W]; // [R5]
                end
                ptit_pkg::PTIT_OFS_CLEAR:
                    evt_clr = pwdata_in[ptit_pkg::PTIT_EVT_W-1:0];
                ptit_pkg::PTIT_OFS_IRQ_ENABLE:
                    irq_en_d = pwdata_in[ptit_pkg::PTIT_EVT_W-1:0];
                // status writes and unmapped offsets change nothing
                default:
                    ctrl_d = ctrl_q;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            ctrl_q <= ptit_pkg::PTIT_CTRL_RESET[3:0]; // [R8]
            irq_en_q <= ptit_pkg::PTIT_EVT_RESET;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            irq_en_q <= irq_en_d;
        end
    end

    // ----------------------------------------------------------------
    // tap selection and tick detection
    // ----------------------------------------------------------------
    // counter bit k has period 2^(k+1), so divisor 2^n sits on bit n-1
    // each rate code is wired to its two fixed stages through a gear mux; the final pick is a mux on the rate
    generate
        for (genvar k = 0; k < 8; k++)
        begin : g_tap
            localparam int STAGE_LOW = int'(ptit_pkg::PTIT_EXP_TABLE[k]) - 1;
            localparam int STAGE_HIGH = STAGE_LOW + 1;
            logic tap_gear_low;
            logic tap_gear_high;
            // a stage past the counter width never toggles, so it reads low
            if (STAGE_LOW < PRESCALER_W)
            begin : g_low
                assign tap_gear_low = prescaler_count_in[STAGE_LOW];
            end
            else
            begin : g_low_off
                assign tap_gear_low = 1'b0;
            end
            if (STAGE_HIGH < PRESCALER_W)
            begin : g_high
                assign tap_gear_high = prescaler_count_in[STAGE_HIGH];
            end
            else
            begin : g_high_off
                assign tap_gear_high = 1'b0;
            end
            // gear high moves the tap one stage up, doubling the divisor
            assign tap_by_code[k] = clock_gear_divider_select_in
                                    ? tap_gear_high : tap_gear_low; // [R6]
        end
    endgenerate

    always_comb
    begin
        // the rate field only steers the final pick among the eight candidates
        tap_index = {2'h0, ctrl_q.rate};
        tap_now = tap_by_code[tap_index[2:0]];
    end

    // a rate change while running is not blocked, so it may show one false fall
    // the prescaler is only observed, never cleared, so the first period may be short
    assign tick_fire = ctrl_q.enable && armed_q && tap_prev_q && !tap_now; // [R2] [R3] [R10]

    always_comb
    begin
        tap_prev_d = tap_now;
        // arming one cycle after enable hides a false edge from a rate change in the same write
        armed_d = ctrl_q.enable; // [R10]
        tick_d = tick_fire; // [R1]
    end

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            tap_prev_q <= 1'b0;
            armed_q <= 1'b0;
            tick_q <= 1'b0;
        end
        else
        begin
            tap_prev_q <= tap_prev_d;
            armed_q <= armed_d;
            tick_q <= tick_d;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status
    // ----------------------------------------------------------------
    assign evt_set.tick = tick_fire;
    // a tick while the previous one is still pending is flagged, not lost silently
    assign evt_set.overrun = tick_fire && status_q.tick && !evt_clr.tick;

    generate
        for (genvar i = 0; i < ptit_pkg::PTIT_EVT_W; i++)
        begin : g_status
            // set wins over a clear in the same cycle; one continuous driver per bit
            assign status_d[i] = evt_set[i] || (status_q[i] && !evt_clr[i]);
        end
    endgenerate

    always_comb
    begin
        // built from the next status so irq rises with the status bit, not a cycle later
        irq_d = |(status_d & irq_en_d);
    end

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            status_q <= ptit_pkg::PTIT_EVT_RESET;
            irq_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            irq_q <= irq_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // every output is a register; nothing reaches a pin straight from the bus
    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign tick_interrupt_request_out = tick_q;
    assign irq_out = irq_q;

endmodule

// >>> testbench/ptit_timer_monitor.sv
// Checker for the tick timer: apb answer timing and tick causes.
// Assumes it sees only the top ports; shadows the control register itself.
`timescale 1ns/10ps
module ptit_timer_monitor
#(
    parameter int PRESCALER_W = 24
)
(
    // clock, reset and apb
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ptit_pkg::PTIT_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // tick side
    input wire logic [PRESCALER_W-1:0] prescaler_count_in,
    input wire logic clock_gear_divider_select_in,
    input wire logic tick_interrupt_request_out,
    input wire logic irq_out
);
    logic [3:0] ctrl_q, ctrl_d;
    logic tap_q, tap_d, fall, setup, unmapped;
    int idx;
    always_comb
    begin
        setup = psel_in && !penable_in;
        unmapped = paddr_in[11:4] != 8'h00 || paddr_in[1:0] != 2'h0;
        ctrl_d = ctrl_q;
        if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == 12'h000 && pstrb_in[0])
            ctrl_d = pwdata_in[3:0];
        idx = int'(ptit_pkg::PTIT_EXP_TABLE[ctrl_q[2:0]]) - 1 + int'(clock_gear_divider_select_in);
        // taps past the counter width read low
        tap_d = (idx < PRESCALER_W) ? prescaler_count_in[idx] : 1'b0;
        fall = tap_q && !tap_d;
    end
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            ctrl_q <= 4'h0;
            tap_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            tap_q <= tap_d;
        end
    end
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);
    a_ready_after_setup: assert property (setup |=> pready_out)
        else $error("no ready after setup");
    a_ready_single: assert property (pready_out |=> !pready_out)
        else $error("ready held too long");
    a_ready_unasked: assert property (!setup |=> !pready_out)
        else $error("ready without setup");
    a_err_unmapped: assert property (setup |=> pslverr_out == $past(unmapped))
        else $error("slave error wrong");
    a_ctrl_readback: assert property (setup && !pwrite_in && paddr_in == 12'h000 |=>
        prdata_out == {28'h0000000, ctrl_q}) else $error("control readback wrong");
    a_tick_on_fall: assert property (fall && ctrl_q[3] && $past(ctrl_q[3]) |=>
        tick_interrupt_request_out) else $error("missed tick");
    a_tick_has_cause: assert property (tick_interrupt_request_out |->
        $past(fall && ctrl_q[3])) else $error("tick without tap fall");
    a_tick_single: assert property (tick_interrupt_request_out |=> !tick_interrupt_request_out)
        else $error("tick longer than one cycle");
    a_disabled_quiet: assert property (!ctrl_q[3] && $past(!ctrl_q[3]) |->
        !tick_interrupt_request_out) else $error("tick while disabled");
    c_tick: cover property (tick_interrupt_request_out);
    c_err: cover property (pready_out && pslverr_out);
    c_irq: cover property ($rose(irq_out));
endmodule
bind ptit_timer ptit_timer_monitor #(.PRESCALER_W(PRESCALER_W)) mon_u (.clk_sys_in, .reset_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out,
    .pready_out, .pslverr_out, .prescaler_count_in, .clock_gear_divider_select_in,
    .tick_interrupt_request_out, .irq_out);

// >>> testbench/ptit_timer_tb.sv
// Self-checking bench for the tick timer, driven over apb.
// Assumes a one-cycle apb answer and a prescaler counter driven by the bench.
`timescale 1ns/10ps
module ptit_timer_tb;
    logic clk_sys_in, reset_in, psel_in, penable_in, pwrite_in, clock_gear_divider_select_in;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, r;
    logic [3:0] pstrb_in;
    logic [23:0] prescaler_count_in;
    logic pready_out, pslverr_out, tick_interrupt_request_out, irq_out, e;
    int miscompares = 0;
    int tests_run = 0;
    int ticks = 0;
    int early = 0;
    int exps [8] = '{23, 21, 16, 14, 13, 12, 11, 9};
    ptit_timer #(.PRESCALER_W(24)) dut_u (.clk_sys_in, .reset_in, .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out,
        .prescaler_count_in, .clock_gear_divider_select_in, .tick_interrupt_request_out,
        .irq_out);
    always #25 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in)
        if (tick_interrupt_request_out === 1'b1)
            ticks++;
    task automatic close_out;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        tests_run++;
        if (s !== x)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys_in);
            n++;
        end
        while (pready_out !== 1'b1 && n < 20);
        r = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        // a transfer that never got ready ends the run
        if (pready_out !== 1'b1)
        begin
            miscompares++;
            $display("[ERR] %0t no ready", $time);
            close_out();
        end
    endtask
    // tap high, other stages fall, then the tap falls; early holds ticks before the tap fell
    task automatic tap(input int i);
        ticks = 0;
        @(posedge clk_sys_in);
        prescaler_count_in <= 24'hFFFFFF;
        repeat (2) @(posedge clk_sys_in);
        prescaler_count_in <= 24'h000001 << i;
        repeat (3) @(posedge clk_sys_in);
        early = ticks;
        prescaler_count_in <= 24'h000000;
        repeat (4) @(posedge clk_sys_in);
    endtask
    initial
    begin
        clk_sys_in = 1'b0;
        reset_in = 1'b1;
        {psel_in, penable_in, pwrite_in, clock_gear_divider_select_in} = 4'h0;
        paddr_in = 12'h000;
        pwdata_in = 32'h0;
        pstrb_in = 4'hF;
        prescaler_count_in = 24'h0;
        repeat (10) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 16; i += 4)
        begin
            rw(1'b0, i[11:0], 32'h0);
            chk(r, 32'h0);
        end
        $display("test reset done");
        rw(1'b1, 12'h000, 32'h0000000D);
        pstrb_in <= 4'h0;
        rw(1'b1, 12'h000, 32'h00000002);
        pstrb_in <= 4'hF;
        rw(1'b0, 12'h000, 32'h0);
        chk(r, 32'h0000000D);
        rw(1'b0, 12'h010, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        rw(1'b1, 12'h000, 32'h5);
        $display("test registers done");
        for (int g = 0; g < 2; g++)
            for (int c = 0; c < 8; c++)
            begin
                // gear and mask are only touched while disabled
                clock_gear_divider_select_in <= g[0];
                rw(1'b1, 12'h00C, g);
                rw(1'b1, 12'h000, 32'h8 | c);
                tap(exps[c] - 1 + g);
                chk(early, 32'h0);
                chk(ticks, 32'h1);
                chk({31'h0, irq_out}, g);
                rw(1'b0, 12'h004, 32'h0);
                chk(r, 32'h1);
                if (c == 7)
                begin
                    // a second tick before the clear also marks the overrun
                    tap(exps[c] - 1 + g);
                    chk(ticks, 32'h1);
                    rw(1'b0, 12'h004, 32'h0);
                    chk(r, 32'h3);
                end
                rw(1'b1, 12'h008, 32'h3);
                repeat (2) @(posedge clk_sys_in);
                chk({31'h0, irq_out}, 32'h0);
                rw(1'b1, 12'h000, c);
                tap(exps[c] - 1 + g);
                chk(ticks, 32'h0);
            end
        $display("test ticks done");
        close_out();
    end
endmodule
